/* File: design/serial_bridge_pkg.sv */
`default_nettype none
package serial_bridge_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL          = 8'h04;
	localparam logic [7:0] ADDR_STATUS        = 8'h08;
	localparam logic [7:0] ADDR_PRIO_VEC      = 8'h0C;
	localparam logic [7:0] ADDR_STAT_CLR      = 8'h10;
	localparam logic [7:0] ADDR_PEND_SET      = 8'h14;
	localparam logic [7:0] ADDR_WR_PTR        = 8'h18;
	localparam logic [7:0] ADDR_TX_BASE       = 8'h1C;
	localparam logic [7:0] ADDR_RX_MAP_FIRST  = 8'h20;
	localparam logic [7:0] ADDR_RX_MAP_LAST   = 8'h3C;

	// ==========================================================
	// Field positions
	localparam int CTRL_SRESET_BIT    = 0;
	localparam int CTRL_LOCAL_BIT     = 1;
	localparam int CTRL_PTR_LOCAL_BIT = 2;
	localparam int CTRL_ERR_EN_BIT    = 3;
	localparam int CTRL_ERR_VEC_LSB   = 8;
	localparam int STAT_LINK_BIT      = 0;
	localparam int STAT_RERR_BIT      = 1;
	localparam int STAT_LERR_BIT      = 2;
	localparam int PRIO_NONE_BIT      = 31;
	localparam int TX_ADDR_BITS       = 26;

	// ==========================================================
	// Reset values and constants
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] REG_RESET     = 32'h0000_0000;
	localparam logic [31:0] PTR_PEND_SET  = {24'h00_0000, ADDR_PEND_SET};
	localparam logic [31:0] XLATE_MISS    = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam int          FLOW_SKID     = 2;

	// ==========================================================
	// Types
	typedef struct packed {
		logic        link_clk;
		logic        link_up;
		logic        rx_req_valid;
		logic [31:0] rx_req_addr;
		logic        rx_word_valid;
		logic        rx_irq_valid;
		logic [31:0] rx_irq_status;
		logic        rx_pkt_error;
		logic        remote_err_report;
		logic        irq_pkt_done;
	} link_in_type;

	typedef enum logic {IRQ_TX_IDLE, IRQ_TX_BUSY} irq_tx_state_type;

endpackage
`default_nettype wire

/* File: design/serial_bridge_xlate_flow_irq.sv */
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none
module serial_bridge_xlate_flow_irq
	import serial_bridge_pkg::*;
#(
	parameter int RX_BUF_DEPTH = 16
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic [31:0] i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [31:0] i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	input  wire link_in_type i_link,
	input  wire logic        i_tx_req_valid,
	input  wire logic [31:0] i_tx_req_addr,
	input  wire logic        i_rx_pop,
	output logic             o_link_enable,
	output logic             o_flow_pause_req,
	output logic             o_tx_addr_valid,
	output logic [31:0]      o_tx_addr,
	output logic             o_rx_xlate_valid,
	output logic [31:0]      o_rx_xlate_addr,
	output logic             o_irq_pkt_valid,
	output logic [31:0]      o_irq_pkt_data,
	output logic             o_irq_ext_wr_valid,
	output logic [31:0]      o_irq_ext_wr_addr,
	output logic [31:0]      o_irq_ext_wr_data,
	output logic             o_module_irq_out
);

	localparam int CNT_W = $clog2(RX_BUF_DEPTH + 1);
	localparam logic [CNT_W-1:0] PAUSE_LEVEL  = CNT_W'(RX_BUF_DEPTH - FLOW_SKID);
	localparam logic [CNT_W-1:0] RESUME_LEVEL = CNT_W'(RX_BUF_DEPTH / 2);
	localparam logic [CNT_W-1:0] FULL_LEVEL   = CNT_W'(RX_BUF_DEPTH);

	// ==========================================================
	// Link input synchroniser and link clock edge finder
	link_in_type link_meta_r;
	link_in_type link_sync_r;
	logic        link_clk_prev_r;
	logic        link_sample;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			link_meta_r     <= '0;
			link_sync_r     <= '0;
			link_clk_prev_r <= 1'b0;
		end else begin
			link_meta_r     <= i_link;
			link_sync_r     <= link_meta_r;
			link_clk_prev_r <= link_sync_r.link_clk;
		end
	end

	// Sample mid-cycle on the falling edge, when link data is settled
	assign link_sample = link_clk_prev_r & ~link_sync_r.link_clk;

	// ==========================================================
	// Register storage
	logic [31:0]      ctrl_r;
	logic [31:0]      pend_r;
	logic [31:0]      stat_irq_r;
	logic [31:0]      wr_ptr_r;
	logic [31:0]      tx_base_r;
	logic [31:0]      rx_size_r [4];
	logic [31:0]      rx_offs_r [4];
	logic             link_up_r;
	logic             rerr_r;
	logic             lerr_r;
	logic             sreset;
	logic             local_mode;

	assign sreset     = ctrl_r[CTRL_SRESET_BIT];
	assign local_mode = ctrl_r[CTRL_LOCAL_BIT];

	// ==========================================================
	// AXI4-Lite slave
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        aw_got_r;
	logic        w_got_r;
	logic        wr_do;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic        wr_mapped;
	logic [31:0] rd_data;
	logic        rd_mapped;

	assign wr_do = aw_got_r & w_got_r & ~o_s_axi_bvalid;
	assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	assign wbits = w_data_r & wmask;
	assign wr_mapped = (aw_addr_r[1:0] == 2'h0) && (aw_addr_r >= ADDR_CTRL) && (aw_addr_r <= ADDR_RX_MAP_LAST)
		&& (aw_addr_r != ADDR_STATUS || 1'b1);

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_addr_r       <= 8'h00;
			w_data_r        <= 32'h0000_0000;
			w_strb_r        <= 4'h0;
			aw_got_r        <= 1'b0;
			w_got_r         <= 1'b0;
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready  <= 1'b1;
			o_s_axi_bvalid  <= 1'b0;
			o_s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_addr_r       <= i_s_axi_awaddr[7:0];
				aw_got_r        <= 1'b1;
				o_s_axi_awready <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_data_r       <= i_s_axi_wdata;
				w_strb_r       <= i_s_axi_wstrb;
				w_got_r        <= 1'b1;
				o_s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_got_r       <= 1'b0;
				w_got_r        <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid  <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready  <= 1'b1;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [31:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// Lowest set bit has the highest priority
	function automatic logic [4:0] prio_index(input logic [31:0] v);
		prio_index = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				prio_index = 5'(i);
			end
		end
	endfunction

	always_comb begin
		rd_data   = 32'h0000_0000;
		rd_mapped = 1'b1;
		case (i_s_axi_araddr[7:0])
			ADDR_CTRL:     rd_data = ctrl_r;
			ADDR_STATUS: begin
				rd_data[STAT_LINK_BIT] = link_up_r;
				rd_data[STAT_RERR_BIT] = rerr_r;
				rd_data[STAT_LERR_BIT] = lerr_r;
			end
			ADDR_PRIO_VEC: begin
				rd_data[PRIO_NONE_BIT] = ~|stat_irq_r;
				rd_data[4:0] = local_mode ? prio_index(stat_irq_r) : 5'h00;
			end
			ADDR_STAT_CLR: rd_data = stat_irq_r;
			ADDR_PEND_SET: rd_data = pend_r;
			ADDR_WR_PTR:   rd_data = wr_ptr_r;
			ADDR_TX_BASE:  rd_data = tx_base_r;
			default: begin
				if (i_s_axi_araddr[7:0] >= ADDR_RX_MAP_FIRST && i_s_axi_araddr[7:0] <= ADDR_RX_MAP_LAST
					&& i_s_axi_araddr[1:0] == 2'h0) begin
					rd_data = i_s_axi_araddr[2] ? rx_offs_r[i_s_axi_araddr[4:3]] : rx_size_r[i_s_axi_araddr[4:3]];
				end else begin
					rd_mapped = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_rdata   <= 32'h0000_0000;
			o_s_axi_rresp   <= RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid  <= 1'b1;
			o_s_axi_rdata   <= rd_data;
			o_s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (o_s_axi_rvalid && i_s_axi_rready) begin
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Plain configuration registers, kept across software reset
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_r    <= CTRL_RESET;
			wr_ptr_r  <= REG_RESET;
			tx_base_r <= REG_RESET;
			for (int i = 0; i < 4; i++) begin
				rx_size_r[i] <= REG_RESET;
				rx_offs_r[i] <= REG_RESET;
			end
		end else if (wr_do) begin
			case (aw_addr_r)
				ADDR_CTRL:    ctrl_r    <= merge(ctrl_r, w_data_r, wmask);
				ADDR_WR_PTR:  wr_ptr_r  <= merge(wr_ptr_r, w_data_r, wmask);
				ADDR_TX_BASE: tx_base_r <= merge(tx_base_r, w_data_r, wmask);
				default: begin
					if (aw_addr_r >= ADDR_RX_MAP_FIRST && aw_addr_r <= ADDR_RX_MAP_LAST && aw_addr_r[1:0] == 2'h0) begin
						if (aw_addr_r[2]) begin
							rx_offs_r[aw_addr_r[4:3]] <= merge(rx_offs_r[aw_addr_r[4:3]], w_data_r, wmask);
						end else begin
							rx_size_r[aw_addr_r[4:3]] <= merge(rx_size_r[aw_addr_r[4:3]], w_data_r, wmask);
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Link status and error flags
	logic link_up_nxt;
	logic rerr_nxt;
	logic lerr_nxt;
	logic stat_wr;

	assign stat_wr     = wr_do && (aw_addr_r == ADDR_STATUS);
	assign link_up_nxt = ~sreset & link_sync_r.link_up;
	always_comb begin
		rerr_nxt = rerr_r;
		lerr_nxt = lerr_r;
		if (stat_wr && wbits[STAT_RERR_BIT]) begin
			rerr_nxt = 1'b0;
		end
		if (stat_wr && wbits[STAT_LERR_BIT]) begin
			lerr_nxt = 1'b0;
		end
		if ((link_up_nxt && !link_up_r) || (link_sample && link_sync_r.remote_err_report && !sreset)) begin
			rerr_nxt = 1'b1;
		end
		if (link_sample && link_sync_r.rx_pkt_error && !sreset) begin
			lerr_nxt = 1'b1;
		end
		if (sreset) begin
			rerr_nxt = 1'b0;
			lerr_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			link_up_r <= 1'b0;
			rerr_r    <= 1'b0;
			lerr_r    <= 1'b0;
		end else begin
			link_up_r <= link_up_nxt;
			rerr_r    <= rerr_nxt;
			lerr_r    <= lerr_nxt;
		end
	end

	// ==========================================================
	// Interrupt pending, status and forwarding
	irq_tx_state_type irq_tx_state_r;
	logic [31:0]      pend_set;
	logic [31:0]      pend_clr;
	logic [31:0]      stat_set;
	logic [31:0]      stat_clr;
	logic [31:0]      stat_irq_nxt;
	logic             rx_irq_evt;
	logic             rx_irq_local;
	logic             err_rise;
	logic             irq_pulse_nxt;

	assign rx_irq_evt   = link_sample & link_sync_r.rx_irq_valid & ~sreset;
	assign rx_irq_local = ctrl_r[CTRL_PTR_LOCAL_BIT] && (wr_ptr_r == PTR_PEND_SET);
	assign err_rise     = (rerr_nxt & ~rerr_r) | (lerr_nxt & ~lerr_r);

	always_comb begin
		pend_set = 32'h0000_0000;
		pend_clr = 32'h0000_0000;
		stat_set = 32'h0000_0000;
		stat_clr = 32'h0000_0000;
		if (wr_do && aw_addr_r == ADDR_PEND_SET) begin
			pend_set = wbits;
		end
		if (rx_irq_evt && rx_irq_local) begin
			pend_set = pend_set | link_sync_r.rx_irq_status;
		end
		if (err_rise && ctrl_r[CTRL_ERR_EN_BIT]) begin
			pend_set[ctrl_r[CTRL_ERR_VEC_LSB +: 5]] = 1'b1;
		end
		if (local_mode) begin
			pend_clr = pend_r;
			stat_set = pend_r;
		end else if (irq_tx_state_r == IRQ_TX_BUSY && link_sample && link_sync_r.irq_pkt_done) begin
			pend_clr = o_irq_pkt_data;
		end
		if (wr_do && aw_addr_r == ADDR_STAT_CLR) begin
			stat_clr = wbits;
		end
		if (wr_do && aw_addr_r == ADDR_PRIO_VEC) begin
			stat_clr[w_data_r[4:0]] = 1'b1;
		end
		stat_irq_nxt = (stat_irq_r & ~stat_clr) | stat_set;
	end

	// Fresh pulse on new status bits, or on a status write that leaves bits set
	assign irq_pulse_nxt = local_mode && (|stat_set || (wr_do && aw_addr_r == ADDR_STAT_CLR && |stat_irq_nxt));

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend_r           <= REG_RESET;
			stat_irq_r       <= REG_RESET;
			o_module_irq_out <= 1'b0;
		end else begin
			pend_r           <= (pend_r & ~pend_clr) | pend_set;
			stat_irq_r       <= stat_irq_nxt;
			o_module_irq_out <= irq_pulse_nxt & ~o_module_irq_out;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_tx_state_r  <= IRQ_TX_IDLE;
			o_irq_pkt_valid <= 1'b0;
			o_irq_pkt_data  <= 32'h0000_0000;
		end else if (sreset) begin
			irq_tx_state_r  <= IRQ_TX_IDLE;
			o_irq_pkt_valid <= 1'b0;
		end else begin
			case (irq_tx_state_r)
				IRQ_TX_IDLE: begin
					if (!local_mode && |pend_r && link_up_r) begin
						irq_tx_state_r  <= IRQ_TX_BUSY;
						o_irq_pkt_valid <= 1'b1;
						o_irq_pkt_data  <= pend_r;
					end
				end
				IRQ_TX_BUSY: begin
					if (link_sample && link_sync_r.irq_pkt_done) begin
						irq_tx_state_r  <= IRQ_TX_IDLE;
						o_irq_pkt_valid <= 1'b0;
					end
				end
				default: begin
					irq_tx_state_r  <= IRQ_TX_IDLE;
					o_irq_pkt_valid <= 1'b0;
				end
			endcase
		end
	end

	// Interrupt status aimed elsewhere goes out as a system write
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_irq_ext_wr_valid <= 1'b0;
			o_irq_ext_wr_addr  <= 32'h0000_0000;
			o_irq_ext_wr_data  <= 32'h0000_0000;
		end else begin
			o_irq_ext_wr_valid <= rx_irq_evt & ~rx_irq_local;
			if (rx_irq_evt && !rx_irq_local) begin
				o_irq_ext_wr_addr <= wr_ptr_r;
				o_irq_ext_wr_data <= link_sync_r.rx_irq_status;
			end
		end
	end

	// ==========================================================
	// Address translation
	logic [31:0] sum12;
	logic [31:0] sum123;
	logic [31:0] sum1234;
	logic [31:0] rx_addr;
	logic [31:0] xlate;

	assign rx_addr = link_sync_r.rx_req_addr;
	assign sum12   = rx_size_r[0] + rx_size_r[1];
	assign sum123  = sum12 + rx_size_r[2];
	assign sum1234 = sum123 + rx_size_r[3];

	always_comb begin
		if (rx_addr < rx_size_r[0]) begin
			xlate = rx_addr + rx_offs_r[0];
		end else if (rx_addr < sum12) begin
			xlate = rx_addr + rx_offs_r[1] - rx_size_r[0];
		end else if (rx_addr < sum123) begin
			xlate = rx_addr + rx_offs_r[2] - sum12;
		end else if (rx_addr < sum1234) begin
			xlate = rx_addr + rx_offs_r[3] - sum123;
		end else begin
			xlate = XLATE_MISS;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rx_xlate_valid <= 1'b0;
			o_rx_xlate_addr  <= 32'h0000_0000;
			o_tx_addr_valid  <= 1'b0;
			o_tx_addr        <= 32'h0000_0000;
		end else begin
			o_rx_xlate_valid <= link_sample & link_sync_r.rx_req_valid & ~sreset;
			if (link_sample && link_sync_r.rx_req_valid) begin
				o_rx_xlate_addr <= xlate;
			end
			o_tx_addr_valid <= i_tx_req_valid & ~sreset & link_up_r;
			if (i_tx_req_valid) begin
				o_tx_addr <= {6'h00, i_tx_req_addr[TX_ADDR_BITS-1:0] - tx_base_r[TX_ADDR_BITS-1:0]};
			end
		end
	end

	// ==========================================================
	// Receive buffer occupancy and flow control
	logic [CNT_W-1:0] rx_fill_r;
	logic             push;
	logic             pop;

	assign push = link_sample & link_sync_r.rx_word_valid & (rx_fill_r != FULL_LEVEL);
	assign pop  = i_rx_pop & (rx_fill_r != '0);

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_fill_r        <= '0;
			o_flow_pause_req <= 1'b0;
			o_link_enable    <= 1'b0;
		end else begin
			o_link_enable <= ~sreset;
			if (sreset) begin
				rx_fill_r        <= '0;
				o_flow_pause_req <= 1'b0;
			end else begin
				if (push && !pop) begin
					rx_fill_r <= rx_fill_r + CNT_W'(1);
				end else if (pop && !push) begin
					rx_fill_r <= rx_fill_r - CNT_W'(1);
				end
				if (rx_fill_r >= PAUSE_LEVEL) begin
					o_flow_pause_req <= 1'b1;
				end else if (rx_fill_r <= RESUME_LEVEL) begin
					o_flow_pause_req <= 1'b0;
				end
			end
		end
	end

endmodule // serial_bridge_xlate_flow_irq
`default_nettype wire

/* File: verification/serial_bridge_xlate_flow_irq_properties.sv */
`default_nettype none
module serial_bridge_xlate_flow_irq_properties
	import serial_bridge_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_arst_n,
	input wire logic [31:0] i_s_axi_awaddr,
	input wire logic        i_s_axi_awvalid,
	input wire logic        o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic        i_s_axi_wvalid,
	input wire logic        o_s_axi_wready,
	input wire logic        o_s_axi_bvalid,
	input wire logic        i_s_axi_bready,
	input wire logic        i_s_axi_arvalid,
	input wire logic        o_s_axi_arready,
	input wire logic        o_s_axi_rvalid,
	input wire logic        i_s_axi_rready,
	input wire link_in_type i_link,
	input wire logic        i_tx_req_valid,
	input wire logic        o_link_enable,
	input wire logic        o_tx_addr_valid,
	input wire logic [31:0] o_tx_addr,
	input wire logic        o_rx_xlate_valid,
	input wire logic        o_irq_pkt_valid,
	input wire logic [31:0] o_irq_pkt_data,
	input wire logic        o_module_irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	logic wr_take;
	assign wr_take = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
	// ====
	// Register bus
	b_answer_a: assert property (wr_take |-> ##2 o_s_axi_bvalid)
		else $error("write answer late");
	aw_refuse_a: assert property (wr_take |=> !o_s_axi_awready [*2])
		else $error("second write taken");
	b_release_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid && o_s_axi_awready)
		else $error("write answer kept");
	r_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
		else $error("read answer late");
	r_release_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid && o_s_axi_arready)
		else $error("read answer kept");
	// ====
	// Link side
	tx_offset_a: assert property (o_tx_addr_valid |-> $past(i_tx_req_valid) && o_tx_addr[31:26] == 6'h00)
		else $error("bad transmit address");
	rx_pulse_a: assert property (o_rx_xlate_valid |=> !o_rx_xlate_valid)
		else $error("translation pulse too long");
	soft_reset_a: assert property (wr_take && i_s_axi_awaddr[7:0] == ADDR_CTRL && i_s_axi_wdata[0]
		|-> ##[1:4] !o_link_enable) else $error("link kept in soft reset");
	pkt_hold_a: assert property (o_irq_pkt_valid && !i_link.irq_pkt_done
		|=> o_irq_pkt_valid && $stable(o_irq_pkt_data)) else $error("packet dropped early");
	irq_pulse_a: assert property (o_module_irq_out |=> !o_module_irq_out)
		else $error("interrupt pulse too long");
	cover property (o_module_irq_out);
	cover property ($fell(o_irq_pkt_valid));
	cover property (o_tx_addr_valid);
endmodule // serial_bridge_xlate_flow_irq_properties
bind serial_bridge_xlate_flow_irq serial_bridge_xlate_flow_irq_properties u_props (
	.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_s_axi_awaddr(i_s_axi_awaddr),
	.i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
	.i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
	.i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready), .i_link(i_link),
	.i_tx_req_valid(i_tx_req_valid), .o_link_enable(o_link_enable), .o_tx_addr_valid(o_tx_addr_valid),
	.o_tx_addr(o_tx_addr), .o_rx_xlate_valid(o_rx_xlate_valid), .o_irq_pkt_valid(o_irq_pkt_valid),
	.o_irq_pkt_data(o_irq_pkt_data), .o_module_irq_out(o_module_irq_out));
`default_nettype wire

/* File: verification/peer_link_model.sv */
`default_nettype none
module peer_link_model
	import serial_bridge_pkg::*;
(
	input  wire logic      i_pause,
	output var link_in_type o_link
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_link = '0;
	// ====
	// One link clock, fields held across the fall
	task automatic frame(input link_in_type v);
		v.link_up = o_link.link_up;
		#37;
		o_link = v;
		o_link.link_clk = 1'b1;
		#400;
		o_link.link_clk = 1'b0;
		#800;
		o_link = '{link_up: v.link_up, rx_req_addr: ~v.rx_req_addr, rx_irq_status: ~v.rx_irq_status, default: '0};
	endtask
	task automatic link(input logic u);
		o_link.link_up = u;
	endtask
	task automatic words(input int n);
		repeat (n) begin
			wait (!i_pause);
			frame('{rx_word_valid: 1'b1, default: '0});
		end
	endtask
endmodule // peer_link_model
`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none
module tb
	import serial_bridge_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, awv, wv, bre, arv, rre, txv, pop;
	logic        awr, wrd, bv, arr, rv, len, pau, txov, xv, pv, ev, irq;
	logic [31:0] awa, wd, ara, txa, rd, txo, xa, pd, ea, ed, v, tq, ewa, ewd;
	logic [1:0]  brsp, rrsp, rs;
	link_in_type lnk;
	int          n_mismatch, cmp_count, nirq;
	logic [31:0] xq[$];
	logic [31:0] sz[4] = '{32'h100, 32'h100, 32'h200, 32'h400};
	logic [31:0] off[4] = '{32'h0200_0000, 32'h8200_0000, 32'h1000_0000, 32'h2000_0000};
	logic [31:0] ra[7] = '{32'hFC, 32'h100, 32'h154, 32'h3FC, 32'h400, 32'h7FC, 32'h800};
	logic [31:0] xe[7] = '{32'h0200_00FC, 32'h8200_0000, 32'h8200_0054, 32'h1000_01FC, 32'h2000_0000,
		32'h2000_03FC, 32'h0};
	serial_bridge_xlate_flow_irq #(.RX_BUF_DEPTH(16)) dut (.i_clk_sys(clk), .i_arst_n(rst_n),
		.i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
		.i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .o_s_axi_bresp(brsp),
		.o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rrsp), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(rre), .i_link(lnk), .i_tx_req_valid(txv), .i_tx_req_addr(txa), .i_rx_pop(pop),
		.o_link_enable(len), .o_flow_pause_req(pau), .o_tx_addr_valid(txov), .o_tx_addr(txo),
		.o_rx_xlate_valid(xv), .o_rx_xlate_addr(xa), .o_irq_pkt_valid(pv), .o_irq_pkt_data(pd),
		.o_irq_ext_wr_valid(ev), .o_irq_ext_wr_addr(ea), .o_irq_ext_wr_data(ed), .o_module_irq_out(irq));
	peer_link_model peer (.i_pause(pau), .o_link(lnk));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (xv) xq.push_back(xa);
		if (txov) tq = txo;
		if (ev) ewa = ea;
		if (ev) ewd = ed;
		if (irq) nirq++;
	end
	// ====
	// Bus tasks
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awa <= {24'h0, a};
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (!bv);
		bre <= 1'b0;
		rs = brsp;
	endtask
	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		ara <= {24'h0, a};
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rre <= 1'b0;
		v = rd;
		rs = rrsp;
		chk(s, e, v);
	endtask
	task automatic popn(input int n);
		@(posedge clk);
		pop <= 1'b1;
		repeat (n) @(posedge clk);
		pop <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#500_000;
		n_mismatch++;
		complete_run();
	end
	// ====
	// Tests
	initial begin
		{rst_n, awv, wv, bre, arv, rre, txv, pop} = '0;
		{awa, wd, ara, txa} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rc("ctrl", ADDR_CTRL, CTRL_RESET);
		rc("pend", ADDR_PEND_SET, REG_RESET);
		rc("unmapped", 8'h44, 32'h0);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		wr(8'h44, 32'h0);
		chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		peer.link(1'b1);
		repeat (10) @(posedge clk);
		rc("status", ADDR_STATUS, 32'h3);
		wr(ADDR_STATUS, 32'h2);
		chk("wr resp", {30'h0, RESP_OKAY}, {30'h0, rs});
		rc("status", ADDR_STATUS, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_RX_MAP_FIRST + 8'(8 * i), sz[i]);
			wr(ADDR_RX_MAP_FIRST + 8'(8 * i + 4), off[i]);
		end
		for (int i = 0; i < 7; i++) peer.frame('{rx_req_valid: 1'b1, rx_req_addr: ra[i], default: '0});
		for (int i = 0; i < 7; i++) chk("xlate", xe[i], xq[i]);
		wr(ADDR_TX_BASE, 32'h100);
		@(posedge clk);
		txa <= 32'hFC00_0154;
		txv <= 1'b1;
		@(posedge clk);
		txv <= 1'b0;
		repeat (3) @(posedge clk);
		chk("tx", 32'h54, tq);
		peer.words(14);
		chk("pause", 32'h1, {31'h0, pau});
		popn(5);
		chk("pause", 32'h1, {31'h0, pau});
		popn(1);
		chk("resume", 32'h0, {31'h0, pau});
		popn(8);
		wr(ADDR_CTRL, 32'h2);
		wr(ADDR_PEND_SET, 32'h28);
		rc("stat", ADDR_STAT_CLR, 32'h28);
		rc("pend", ADDR_PEND_SET, 32'h0);
		chk("irq", 32'h1, nirq);
		rc("prio", ADDR_PRIO_VEC, 32'h3);
		wr(ADDR_PRIO_VEC, 32'h3);
		rc("stat", ADDR_STAT_CLR, 32'h20);
		wr(ADDR_STAT_CLR, 32'h0);
		rc("prio", ADDR_PRIO_VEC, 32'h5);
		chk("irq", 32'h2, nirq);
		wr(ADDR_STAT_CLR, 32'h20);
		rc("prio", ADDR_PRIO_VEC, 32'h8000_0000);
		wr(ADDR_WR_PTR, PTR_PEND_SET);
		wr(ADDR_CTRL, 32'h6);
		peer.frame('{rx_irq_valid: 1'b1, rx_irq_status: 32'h100, default: '0});
		rc("remote", ADDR_STAT_CLR, 32'h100);
		wr(ADDR_STAT_CLR, 32'h100);
		wr(ADDR_WR_PTR, 32'h40);
		peer.frame('{rx_irq_valid: 1'b1, rx_irq_status: 32'h200, default: '0});
		chk("ext addr", 32'h40, ewa);
		chk("ext data", 32'h200, ewd);
		wr(ADDR_CTRL, 32'h50A);
		peer.frame('{rx_pkt_error: 1'b1, default: '0});
		rc("lerr", ADDR_STATUS, 32'h5);
		rc("errirq", ADDR_STAT_CLR, 32'h20);
		wr(ADDR_STATUS, 32'h4);
		wr(ADDR_STAT_CLR, 32'h20);
		peer.frame('{remote_err_report: 1'b1, default: '0});
		rc("rerr", ADDR_STATUS, 32'h3);
		rc("errirq", ADDR_STAT_CLR, 32'h20);
		wr(ADDR_STATUS, 32'h2);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_PEND_SET, 32'h1);
		rc("pend", ADDR_PEND_SET, 32'h1);
		chk("pkt", 32'h1, pd);
		chk("pkt valid", 32'h1, {31'h0, pv});
		peer.frame('{irq_pkt_done: 1'b1, default: '0});
		rc("pend", ADDR_PEND_SET, 32'h0);
		chk("pkt valid", 32'h0, {31'h0, pv});
		wr(ADDR_CTRL, 32'h1);
		rc("soft link", ADDR_STATUS, 32'h0);
		chk("enable", 32'h0, {31'h0, len});
		rc("kept", ADDR_TX_BASE, 32'h100);
		wr(ADDR_CTRL, 32'h0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("enable", 32'h0, {31'h0, len});
		rst_n <= 1'b1;
		rc("hard base", ADDR_TX_BASE, REG_RESET);
		complete_run();
	end
endmodule // tb
`default_nettype wire
